// ===== core/swrc_pkg.sv
// package of the single-wire reset control block: register map, timing, command codes
// assumes a 200 MHz core clock; times are converted to cycles here
// How it works
// RULE1: smart reset idle unless input supply valid
// RULE2: deglitch 150 ms after supply becomes valid
// RULE3: pending goes high after deglitch ends
// RULE4: reset pulse after 4000 ms or on request
// RULE5: one reset pulse per supply connection
// RULE6: pending stays high until pulse condition
// RULE7: command 27 enables, 26 disables watchdog
// RULE8: watchdog on: request input clears next pulse
// RULE9: processor clears watchdog 100 us before edge
// RULE10: watchdog pulse every 4000 ms after pending
// RULE11: disable command returns to smart reset
// RULE12: watchdog keeps running without valid supply
// RULE13: reset outputs never touch other settings
// RULE14: load switches set only by commands
// RULE15: host holds command line low when idle
// RULE16: switches default to A; counts 1-8 toggle
// RULE17: command 9 opens, 10 closes monitor switch
// RULE18: command 11 disables end-of-charge detection
// RULE19: commands 12/13 select 5 or 2.5 percent
// RULE20: commands 14-17 select overcurrent limit
// RULE21: commands 18-22 select float voltage offset
// RULE22: host pulses 100 to 120 us wide
// RULE23: start bit 350-400 us, stop bit 500 us
// RULE24: apply count only at stop bit
// RULE25: command replaces only its own group
package swrc_pkg;
	localparam int CLK_MHZ = 200;
	localparam int DEGLITCH_MS = 150;
	localparam int RESET_DELAY_MS = 4000;
	localparam int RESET_PULSE_US = 100;
	localparam int START_MIN_US = 350;
	localparam int STOP_MIN_US = 500;
	localparam int DEGLITCH_CYC = DEGLITCH_MS * 1000 * CLK_MHZ;
	localparam int RESET_DELAY_CYC = RESET_DELAY_MS * 1000 * CLK_MHZ;
	localparam int RESET_PULSE_CYC = RESET_PULSE_US * CLK_MHZ;
	// a high level of at least 200 us, 150 us under the start minimum, counts as a start bit
	localparam int START_CYC = (START_MIN_US - 150) * CLK_MHZ;
	// low spell that closes a command; below the stop minimum to allow slack
	localparam int STOP_CYC = (STOP_MIN_US - 100) * CLK_MHZ;
	localparam int CNT_W = 32;

	localparam logic [5:0] CMD_WDOG_OFF = 6'h1A;
	localparam logic [5:0] CMD_WDOG_ON  = 6'h1B;

	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_CFG    = 12'h008;

	typedef enum logic [1:0] {
		EOC_OFF  = 2'h0,
		EOC_5PC  = 2'h1,
		EOC_2P5  = 2'h2
	} swrc_eoc_t;

	typedef struct packed {
		logic [1:0] pathA;       // [0] path1, [1] path2
		logic [1:0] pathB;
		logic       batMon;
		swrc_eoc_t  eoc;
		logic [1:0] ocLimit;     // 0:900 1:450 2:250 3:100 mA
		logic [2:0] floatOfs;    // 0..4 x 50 mV
		logic       wdogEn;
	} swrc_cfg_t;

	localparam swrc_cfg_t CFG_RESET = '{pathA: 2'h3, pathB: 2'h0, batMon: 1'b0,
		eoc: EOC_5PC, ocLimit: 2'h0, floatOfs: 3'h0, wdogEn: 1'b0};

	typedef enum logic [1:0] {
		RS_IDLE    = 2'h0,
		RS_DEGL    = 2'h1,
		RS_PENDING = 2'h2,
		RS_DONE    = 2'h3
	} swrc_rst_t;

	typedef enum logic [1:0] {
		SW_IDLE  = 2'h0,
		SW_START = 2'h1,
		SW_COUNT = 2'h2
	} swrc_sw_t;
endpackage

// ===== core/swrc_top.sv
// single-wire command decoder and smart reset / watchdog generator with AXI4-Lite access
// assumes async pins arrive raw and are synchronised here; supply-valid comes from analog
module swrc_top import swrc_pkg::*; #(
	parameter int DEGLITCH_CYCLES = DEGLITCH_CYC,
	parameter int DELAY_CYCLES    = RESET_DELAY_CYC,
	parameter int START_CYCLES    = START_CYC,
	parameter int STOP_CYCLES     = STOP_CYC,
	parameter int PULSE_CYCLES    = RESET_PULSE_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        supplyValid,
	input  wire logic        reset_request_in,
	input  wire logic        single_wire_cmd_in,
	output logic             host_reset_out_n,
	output logic             resetPending,
	output logic             path1_out_a,
	output logic             path1_out_b,
	output logic             path2_out_a,
	output logic             path2_out_b,
	output logic             battery_monitor_switch,
	output logic [1:0]       termination_current,
	output logic [1:0]       discharge_overcurrent_limit,
	output logic [2:0]       floatOffset,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// synchronisers
	logic [1:0] syncSup, syncReq, syncCmd;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			syncSup <= 2'h0;
			syncReq <= 2'h0;
			syncCmd <= 2'h0;
		end else begin
			syncSup <= {syncSup[0], supplyValid};
			syncReq <= {syncReq[0], reset_request_in};
			syncCmd <= {syncCmd[0], single_wire_cmd_in};
		end
	end
	logic supOk, reqIn, cmdIn;
	assign supOk = syncSup[1];
	assign reqIn = syncReq[1];
	assign cmdIn = syncCmd[1];

	// single-wire decoder
	swrc_sw_t        swState, next_swState;
	logic [CNT_W-1:0] swTimer, next_swTimer;
	logic [5:0]      pulseCnt, next_pulseCnt;
	logic            cmdPrev, next_cmdPrev;
	logic            cmdStrobe;
	swrc_cfg_t       cfg, next_cfg;
	logic            swTimerRestart;

	always_comb begin
		next_swState  = swState;
		next_pulseCnt = pulseCnt;
		next_cmdPrev  = cmdIn;
		cmdStrobe     = 1'b0;
		swTimerRestart = (cmdIn != cmdPrev);
		next_swTimer  = swTimerRestart ? '0 : swTimer + CNT_W'(1);
		case (swState)
			SW_IDLE: begin
				// a long high level is taken as the start bit
				if (cmdIn && swTimer >= CNT_W'(START_CYCLES)) begin
					next_swState = SW_START;
				end
			end
			SW_START: begin
				if (!cmdIn) begin
					next_swState  = SW_COUNT;
					next_pulseCnt = 6'h00;
				end
			end
			SW_COUNT: begin
				if (cmdIn && !cmdPrev) begin
					next_pulseCnt = pulseCnt + 6'h01; // see RULE24
				end
				if (!cmdIn && swTimer >= CNT_W'(STOP_CYCLES)) begin
					cmdStrobe    = 1'b1; // see RULE24
					next_swState = SW_IDLE;
				end
			end
			default: next_swState = SW_IDLE;
		endcase
	end

	always_comb begin
		next_cfg = cfg;
		if (cmdStrobe) begin
			case (pulseCnt) // see RULE25
				6'h01: next_cfg.pathA[0] = 1'b0; // see RULE16
				6'h02: next_cfg.pathA[0] = 1'b1;
				6'h03: next_cfg.pathB[0] = 1'b0;
				6'h04: next_cfg.pathB[0] = 1'b1;
				6'h05: next_cfg.pathA[1] = 1'b0;
				6'h06: next_cfg.pathA[1] = 1'b1;
				6'h07: next_cfg.pathB[1] = 1'b0;
				6'h08: next_cfg.pathB[1] = 1'b1;
				6'h09: next_cfg.batMon = 1'b0; // see RULE17
				6'h0A: next_cfg.batMon = 1'b1;
				6'h0B: next_cfg.eoc = EOC_OFF; // see RULE18
				6'h0C: next_cfg.eoc = EOC_5PC; // see RULE19
				6'h0D: next_cfg.eoc = EOC_2P5;
				6'h0E, 6'h0F, 6'h10, 6'h11: next_cfg.ocLimit = 2'(pulseCnt - 6'h0E); // see RULE20
				6'h12, 6'h13, 6'h14, 6'h15, 6'h16:
					next_cfg.floatOfs = 3'(pulseCnt - 6'h12); // see RULE21
				CMD_WDOG_OFF: next_cfg.wdogEn = 1'b0; // see RULE7 RULE11
				CMD_WDOG_ON: next_cfg.wdogEn = 1'b1; // see RULE7
				default: next_cfg = cfg; // see RULE24
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			swState  <= SW_IDLE;
			swTimer  <= '0;
			pulseCnt <= 6'h00;
			cmdPrev  <= 1'b0;
			cfg      <= CFG_RESET; // see RULE16
		end else begin
			swState  <= next_swState;
			swTimer  <= next_swTimer;
			pulseCnt <= next_pulseCnt;
			cmdPrev  <= next_cmdPrev;
			cfg      <= next_cfg; // see RULE14
		end
	end

	// reset / watchdog generator; it only drives its own two outputs
	swrc_rst_t        rsState, next_rsState;
	logic [CNT_W-1:0] rsTimer, next_rsTimer;
	logic [CNT_W-1:0] pulseTimer, next_pulseTimer;
	logic             skipNext, next_skipNext;

	always_comb begin
		next_rsState    = rsState;
		next_rsTimer    = rsTimer + CNT_W'(1);
		next_skipNext   = skipNext;
		next_pulseTimer = (pulseTimer != '0) ? pulseTimer - CNT_W'(1) : '0;
		case (rsState)
			RS_IDLE: begin
				next_rsTimer = '0;
				if (supOk) next_rsState = RS_DEGL; // see RULE1
			end
			RS_DEGL: begin
				if (!supOk) begin
					next_rsState = RS_IDLE; // see RULE2
				end else if (rsTimer >= CNT_W'(DEGLITCH_CYCLES - 1)) begin
					next_rsState  = RS_PENDING; // see RULE3
					next_rsTimer  = '0;
					next_skipNext = 1'b0;
				end
			end
			RS_PENDING: begin
				if (cfg.wdogEn && reqIn) next_skipNext = 1'b1; // see RULE8
				if (!cfg.wdogEn && reqIn) begin
					next_pulseTimer = CNT_W'(PULSE_CYCLES); // see RULE4
					next_rsState    = RS_DONE; // see RULE6
				end else if (rsTimer >= CNT_W'(DELAY_CYCLES - 1)) begin
					next_rsTimer = '0;
					if (!(cfg.wdogEn && (skipNext || reqIn))) begin
						next_pulseTimer = CNT_W'(PULSE_CYCLES); // see RULE10
					end
					next_skipNext = 1'b0;
					if (!cfg.wdogEn) next_rsState = RS_DONE; // see RULE5 RULE11
				end else if (!supOk && !cfg.wdogEn) begin
					next_rsState = RS_IDLE; // see RULE12
				end
			end
			RS_DONE: begin
				next_rsTimer = '0;
				if (cfg.wdogEn) begin
					// watchdog enabled after the one-shot pulse restarts the period
					next_rsState  = RS_PENDING; // see RULE10
					next_skipNext = 1'b0;
				end else if (!supOk) begin
					next_rsState = RS_IDLE; // see RULE5
				end
			end
			default: next_rsState = RS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rsState          <= RS_IDLE;
			rsTimer          <= '0;
			pulseTimer       <= '0;
			skipNext         <= 1'b0;
			host_reset_out_n <= 1'b1;
			resetPending     <= 1'b0;
		end else begin
			rsState          <= next_rsState;
			rsTimer          <= next_rsTimer;
			pulseTimer       <= next_pulseTimer;
			skipNext         <= next_skipNext;
			host_reset_out_n <= (next_pulseTimer == '0); // see RULE13
			resetPending     <= (next_rsState == RS_PENDING); // see RULE6
		end
	end

	// outputs of the configuration
	always_ff @(posedge core_clk) begin
		if (srst) begin
			path1_out_a <= 1'b1;
			path1_out_b <= 1'b0;
			path2_out_a <= 1'b1;
			path2_out_b <= 1'b0;
			battery_monitor_switch      <= 1'b0;
			termination_current         <= EOC_5PC;
			discharge_overcurrent_limit <= 2'h0;
			floatOffset                 <= 3'h0;
		end else begin
			path1_out_a <= cfg.pathA[0];
			path1_out_b <= cfg.pathB[0];
			path2_out_a <= cfg.pathA[1];
			path2_out_b <= cfg.pathB[1];
			battery_monitor_switch      <= cfg.batMon;
			termination_current         <= cfg.eoc;
			discharge_overcurrent_limit <= cfg.ocLimit;
			floatOffset                 <= cfg.floatOfs;
		end
	end

	// AXI4-Lite: registers are read-only views; writes answered OKAY and ignored
	logic awTaken, wTaken, next_awTaken, next_wTaken, next_bvalid;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	assign s_axi_awready = !awTaken && !s_axi_bvalid;
	assign s_axi_wready  = !wTaken && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_bresp   = 2'h0;

	always_comb begin
		next_awTaken = awTaken || (s_axi_awvalid && s_axi_awready);
		next_wTaken  = wTaken || (s_axi_wvalid && s_axi_wready);
		next_bvalid  = s_axi_bvalid && !s_axi_bready;
		if (next_awTaken && next_wTaken) begin
			next_bvalid  = 1'b1;
			next_awTaken = 1'b0;
			next_wTaken  = 1'b0;
		end
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = 2'h0;
			case (s_axi_araddr)
				ADDR_CTRL:   next_rdata = {31'h0, cfg.wdogEn};
				ADDR_STATUS: next_rdata = {28'h0, supOk, skipNext, resetPending,
					host_reset_out_n};
				ADDR_CFG:    next_rdata = {19'h0, cfg};
				default: begin
					next_rdata = 32'h0;
					next_rresp = 2'h2;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			awTaken      <= 1'b0;
			wTaken       <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end else begin
			awTaken      <= next_awTaken;
			wTaken       <= next_wTaken;
			s_axi_bvalid <= next_bvalid;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
		end
	end
endmodule // swrc_top

// ===== tb/single_wire_reset_control_tb.sv
// self-checking bench for the reset generator and command decoder
// assumes short deglitch and delay counts set here
module single_wire_reset_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DG = 50;
	localparam int DL = 2000;
	// start and stop thresholds and 100 us, all a thousandfold shorter
	localparam int SC = 40;
	localparam int SP = 80;
	localparam int PW = 20;
	logic core_clk, srst, supplyValid, single_wire_cmd_in, reset_request_in, prevN;
	logic host_reset_out_n, resetPending, path1_out_a, path1_out_b, path2_out_a, path2_out_b;
	logic battery_monitor_switch;
	logic [1:0] termination_current, discharge_overcurrent_limit, s_axi_bresp, s_axi_rresp;
	logic [2:0] floatOffset;
	logic [11:0] s_axi_awaddr, s_axi_araddr, ePins, lastPins;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] pinQ[$];
	logic [33:0] rspQ[$];
	int num_errors, total_checks, pulses, n;
	wire [11:0] pins = {path1_out_a, path1_out_b, path2_out_a, path2_out_b, battery_monitor_switch,
		termination_current, discharge_overcurrent_limit, floatOffset};
	swrc_top #(.DEGLITCH_CYCLES(DG), .DELAY_CYCLES(DL), .START_CYCLES(SC), .STOP_CYCLES(SP),
		.PULSE_CYCLES(PW)) DUT (.*);
	swrc_host_model #(.START_HOLD(75), .STOP_HOLD(100)) host (.core_clk(core_clk),
		.single_wire_cmd_in(single_wire_cmd_in), .reset_request_in(reset_request_in));
	always #2.5 core_clk = ~core_clk;
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		for (n = 0; n < lim && s !== v; n++) @(posedge core_clk);
	endtask
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	task automatic cmd(input int c);
		logic [11:0] o;
		o = ePins;
		if (c >= 1 && c <= 8) ePins[11 - (c - 1) / 2] = (c % 2 == 0);
		if (c == 9 || c == 10) ePins[7] = (c == 10);
		if (c >= 11 && c <= 13) ePins[6:5] = 2'(c - 11);
		if (c >= 14 && c <= 17) ePins[4:3] = 2'(c - 14);
		if (c >= 18 && c <= 22) ePins[2:0] = 3'(c - 18);
		if (ePins != o) pinQ.push_back(ePins);
		host.send(c, PW + $urandom % 5, 2 + $urandom % 4);
	endtask
	task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
		rspQ.push_back(e);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		rspQ.push_back(34'h0);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask
	// compares each settled result with the oldest note
	always @(posedge core_clk) begin
		prevN <= host_reset_out_n;
		if (!srst && prevN === 1'b1 && host_reset_out_n === 1'b0) pulses++;
		if (!srst && pins !== lastPins) check(34'(pins), pinQ.size() ? 34'(pinQ.pop_front()) : 'x);
		lastPins <= pins;
		if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, rspQ.pop_front());
		if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rspQ.pop_front());
	end
	initial begin
		{core_clk, srst, supplyValid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h10;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		ePins = 12'hA20;
		void'($urandom(32'hA220));
		wait_cyc(10);
		srst <= 1'b0;
		wait_cyc(100);
		check(34'(pins), 34'hA20);
		check(34'(resetPending), 34'h0);
		supplyValid <= 1'b1;
		wait_lvl(resetPending, 1'b1, 200);
		check(34'(n >= DG), 34'h1);
		wait_lvl(host_reset_out_n, 1'b0, DL + 100);
		check(34'(n >= DL - 10 && n <= DL + 10), 34'h1);
		wait_cyc(3 * DL);
		check({33'h0, resetPending}, 34'h0);
		check(34'(pulses), 34'h1);
		supplyValid <= 1'b0;
		wait_cyc(20);
		supplyValid <= 1'b1;
		wait_lvl(resetPending, 1'b1, 200);
		host.set_req(1'b1);
		wait_lvl(host_reset_out_n, 1'b0, 20);
		check(34'(n < 20), 34'h1);
		host.set_req(1'b0);
		cmd(27);
		axi_rd(12'h000, 34'h1);
		axi_wr(12'h000, 32'h0);
		axi_rd(12'h000, 34'h1);
		axi_rd(12'h010, {2'h2, 32'h0});
		n = pulses;
		wait_cyc(3 * DL);
		check(34'(pulses - n >= 2), 34'h1);
		supplyValid <= 1'b0;
		n = pulses;
		wait_cyc(3 * DL);
		check(34'(pulses - n >= 2), 34'h1);
		wait_lvl(host_reset_out_n, 1'b0, DL + 100);
		host.set_req(1'b1);
		wait_cyc(1);
		n = pulses;
		wait_cyc(3 * DL);
		check(34'(pulses), 34'(n));
		host.set_req(1'b0);
		cmd(26);
		axi_rd(12'h000, 34'h0);
		n = pulses;
		supplyValid <= 1'b1;
		wait_cyc(DG + 3 * DL);
		check(34'(pulses - n), 34'h1);
		for (int c = 0; c <= 23; c++) cmd(c);
		cmd(12);
		wait_cyc(10);
		check(34'(pinQ.size()), 34'h0);
		axi_rd(12'h008, 34'h1F78);
		stop_test;
	end
	initial begin
		wait_cyc(100000);
		num_errors++;
		stop_test;
	end
endmodule // single_wire_reset_control_tb

// ===== tb/swrc_checker_sva.sv
// timing checker for the reset generator, command decoder and register port
// assumes it sees only the top ports and the design's cycle parameters
module swrc_checker import swrc_pkg::*; #(
	parameter int DEGLITCH_CYCLES = DEGLITCH_CYC,
	parameter int DELAY_CYCLES    = RESET_DELAY_CYC,
	parameter int STOP_CYCLES     = STOP_CYC,
	parameter int PULSE_CYCLES    = RESET_PULSE_CYC
) (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        supplyValid,
	input wire logic        single_wire_cmd_in,
	input wire logic        host_reset_out_n,
	input wire logic        resetPending,
	input wire logic        path1_out_a,
	input wire logic        path1_out_b,
	input wire logic        path2_out_a,
	input wire logic        path2_out_b,
	input wire logic        battery_monitor_switch,
	input wire logic [1:0]  termination_current,
	input wire logic [1:0]  discharge_overcurrent_limit,
	input wire logic [2:0]  floatOffset,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [11:0] cfgPins;
	int unsigned lowCnt;
	int unsigned svCnt;
	int unsigned swLow;
	assign cfgPins = {path1_out_a, path1_out_b, path2_out_a, path2_out_b, battery_monitor_switch,
		termination_current, discharge_overcurrent_limit, floatOffset};
	// cycles of reset low, supply high and command line low
	always_ff @(posedge core_clk) begin
		lowCnt <= (srst || host_reset_out_n) ? 0 : lowCnt + 1;
		svCnt <= (srst || !supplyValid) ? 0 : svCnt + 1;
		swLow <= (srst || single_wire_cmd_in) ? 0 : swLow + 1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	chk_pulse_width: assert property ($rose(host_reset_out_n) |-> lowCnt == PULSE_CYCLES)
		else $error("reset pulse width wrong");
	chk_pending_deglitch: assert property ($rose(resetPending) |-> svCnt >= DEGLITCH_CYCLES)
		else $error("pending rose before deglitch");
	chk_cfg_at_stop: assert property (!$stable(cfgPins) && !$past(srst) |->
		swLow >= STOP_CYCLES && swLow <= STOP_CYCLES + 8)
		else $error("setting changed outside stop bit");
	chk_pulse_no_cfg: assert property ($fell(host_reset_out_n) |-> $stable(cfgPins))
		else $error("reset pulse altered settings");
	chk_reset_values: assert property ($past(srst) |-> host_reset_out_n && !resetPending &&
		path1_out_a && path2_out_a && !path1_out_b && !path2_out_b)
		else $error("wrong values after reset");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid)
		else $error("write answer late");
	cov_pulse: cover property ($rose(host_reset_out_n));
	cov_cfg: cover property (!$stable(cfgPins));
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // swrc_checker

bind swrc_top swrc_checker #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES), .DELAY_CYCLES(DELAY_CYCLES),
	.STOP_CYCLES(STOP_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);

// ===== tb/swrc_host_model.sv
// command host and application processor facing the reset block
// assumes calls come just after a rising clock edge
module swrc_host_model #(
	parameter int START_HOLD = 75000,
	parameter int STOP_HOLD  = 100000
) (
	input wire logic core_clk,
	output logic     single_wire_cmd_in,
	output logic     reset_request_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		single_wire_cmd_in = 1'b0;
		reset_request_in = 1'b0;
	end
	task automatic hold(input logic lvl, input int cyc);
		single_wire_cmd_in <= lvl;
		repeat (cyc) @(posedge core_clk);
	endtask
	task automatic set_req(input logic lvl);
		reset_request_in <= lvl;
	endtask
	task automatic send(input int n, input int pw, input int gap);
		hold(1'b1, START_HOLD);
		for (int i = 0; i < n; i++) begin
			hold(1'b0, gap);
			hold(1'b1, pw);
		end
		hold(1'b0, STOP_HOLD);
	endtask
endmodule // swrc_host_model
